// *** bench/board_pads.sv ***
`timescale 1ns/1ps

// Board side of the macrocell pins; an undriven pin is pulled up.
module board_pads (
  // Pins.
  input  wire [7:0] cell_out,
  input  wire [7:0] cell_oe,
  output wire [7:0] cell_in
);
  assign cell_in = (cell_out & cell_oe) | ~cell_oe;
endmodule // board_pads

// *** bench/macrocell_array_assertions.sv ***
`timescale 1ns/1ps
`include "macrocell_array_defines.vh"

module macrocell_array_checker #(
  parameter CELLS  = 8,
  parameter INPUTS = 8,
  parameter ADDR_W = 10
) (
  // Clock, reset and bus.
  input wire              clk,
  input wire              rst,
  input wire              wb_cyc_i,
  input wire              wb_stb_i,
  input wire              wb_we_i,
  input wire [ADDR_W-1:0] wb_adr_i,
  input wire [3:0]        wb_sel_i,
  input wire [31:0]       wb_dat_i,
  input wire [31:0]       wb_dat_o,
  input wire              wb_ack_o,
  // Pins.
  input wire [INPUTS-1:0] in_pins,
  input wire              pin_first,
  input wire              pin_tenth_n,
  input wire [CELLS-1:0]  cell_in,
  input wire [CELLS-1:0]  cell_out,
  input wire [CELLS-1:0]  cell_oe
);
  // Shadow of the configuration written over the bus.
  reg  [1:0]       mode_reg;
  reg  [CELLS-1:0] io_reg;
  reg  [CELLS-1:0] drv_reg;
  wire             wr_hit = wb_ack_o && wb_we_i && wb_sel_i[0];
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_reg <= `RST_GLOBAL_CFG;
      io_reg   <= {CELLS{1'b0}};
      drv_reg  <= {CELLS{1'b0}};
    end else if (wr_hit) begin
      if (wb_adr_i == `OFF_GLOBAL_CFG) mode_reg <= wb_dat_i[1:0];
      if (wb_adr_i == `OFF_IO_SELECT) io_reg <= wb_dat_i[CELLS-1:0];
      if (wb_adr_i == `OFF_DRIVE_TYPE) drv_reg <= wb_dat_i[CELLS-1:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_ack_after_req: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_dat_hold: assert property (!wb_ack_o |-> $stable(wb_dat_o))
    else $error("read data moved without ack");
  a_unmapped_zero: assert property ((wb_ack_o && !wb_we_i && wb_adr_i == 10'h028)
    |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_reset_quiet: assert property ($past(rst) |-> (cell_oe == 0 && cell_out == 0))
    else $error("pins active after reset");
  a_reg_float: assert property ((mode_reg == `MODE_REGISTERED && pin_tenth_n)
    |=> (cell_oe & ~$past(io_reg)) == 0)
    else $error("registered cell driven while disabled");
  a_od_low: assert property ((cell_out & $past(drv_reg)) == 0)
    else $error("open-drain cell driven high");
  cover property (mode_reg == `MODE_REGISTERED && pin_tenth_n);
  cover property ($rose(pin_first) && mode_reg == `MODE_REGISTERED);
  cover property (wb_ack_o && wb_we_i);
endmodule // macrocell_array_checker

bind macrocell_array macrocell_array_checker #(.CELLS(CELLS), .INPUTS(INPUTS), .ADDR_W(ADDR_W))
  u_chk (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .in_pins(in_pins), .pin_first(pin_first), .pin_tenth_n(pin_tenth_n),
  .cell_in(cell_in), .cell_out(cell_out), .cell_oe(cell_oe));

// *** bench/tb_macrocell_array.sv ***
`timescale 1ns/1ps
`include "macrocell_array_defines.vh"

module tb_macrocell_array;
  reg         clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, p1 = 0, p10 = 0;
  reg  [9:0]  adr = 0;
  reg  [3:0]  sel = 0;
  reg  [31:0] dat = 0, rdat;
  reg  [7:0]  ins = 0;
  wire [31:0] dato;
  wire        ack;
  wire [7:0]  cin, cout, coe;
  integer     mismatches = 0, n_compared = 0, k;
  always #50 clk = ~clk;
  macrocell_array u_macrocell_array (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dato),
    .wb_ack_o(ack), .in_pins(ins), .pin_first(p1), .pin_tenth_n(p10), .cell_in(cin),
    .cell_out(cout), .cell_oe(coe));
  board_pads u_board_pads (.cell_out(cout), .cell_oe(coe), .cell_in(cin));
  ////////////////////////////////////////////////////////////////////////////////
  task wrap_up;
    begin
      if (mismatches == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  task cmp(input [31:0] g, input [31:0] e);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
    end
  endtask
  task wb(input w, input [9:0] a, input [31:0] d);
    integer n;
    begin
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      sel <= 4'hf;
      // Look at ack between edges, so that the next edge is the one that samples it high.
      @(posedge clk);
      #1;
      while (ack !== 1'b1 && n < 20) begin
        @(posedge clk);
        #1;
        n = n + 1;
      end
      if (n == 20) begin
        mismatches = mismatches + 1;
        $display("unexpected at %0t: no ack", $time);
      end
      @(posedge clk);
      rdat = dato;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
    end
  endtask
  task rd(input [9:0] a, input [31:0] e);
    begin
      wb(1'b0, a, 32'h0);
      cmp(rdat, e);
    end
  endtask
  // Outputs follow a change after one registered stage.
  task pins(input [7:0] eo, input [7:0] ee);
    begin
      repeat (2) @(posedge clk);
      cmp({16'h0, cout, coe}, {16'h0, eo, ee});
    end
  endtask
  task pulse;
    begin
      p1 <= 1'b1;
      repeat (3) @(posedge clk);
      p1 <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    mismatches = mismatches + 1;
    wrap_up;
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(`OFF_GLOBAL_CFG, 32'h1);
    rd(`OFF_TERM_DIS_LO, 32'hffffffff);
    rd(`OFF_DRIVE_TYPE, 32'h0);
    rd(10'h028, 32'h0);
    wb(1'b1, `OFF_TERM_DIS_LO, 32'hfffffffe);
    pins(8'h01, 8'hff);
    wb(1'b1, `OFF_POLARITY, 32'h1);
    pins(8'h00, 8'hff);
    wb(1'b1, `OFF_DRIVE_TYPE, 32'h1);
    wb(1'b1, `OFF_POLARITY, 32'h0);
    pins(8'h00, 8'hfe);
    wb(1'b1, `OFF_IO_SELECT, 32'hff);
    pins(8'h00, 8'h18);
    wb(1'b1, `OFF_IO_SELECT, 32'h0);
    wb(1'b1, `OFF_DRIVE_TYPE, 32'h0);
    wb(1'b1, 10'h100, 32'h10000);
    for (k = 0; k < 2; k = k + 1) begin
      p1 <= k[0];
      pins({7'h0, k[0]}, 8'hff);
    end
    p1 <= 1'b0;
    wb(1'b1, `OFF_GLOBAL_CFG, 32'h2);
    wb(1'b1, 10'h100, 32'h20000);
    pins(8'h00, 8'hff);
    pulse;
    pins(8'h01, 8'hff);
    p10 <= 1'b1;
    pulse;
    cmp({24'h0, coe}, 32'h0);
    p10 <= 1'b0;
    pins(8'h00, 8'hff);
    wb(1'b1, `OFF_PRELOAD, 32'ha5);
    rd(`OFF_PRELOAD, 32'ha5);
    pins(8'ha5, 8'hff);
    wb(1'b1, `OFF_GLOBAL_CFG, 32'h3);
    wb(1'b1, `OFF_TERM_DIS_LO, 32'hfffffcff);
    pins(8'h02, 8'h02);
    wrap_up;
  end
endmodule // tb_macrocell_array

// *** hdl/macrocell_array.v ***
// The Wishbone register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "macrocell_array_defines.vh"

module macrocell_array #(
  parameter CELLS  = 8,
  parameter INPUTS = 8,
  parameter ADDR_W = 10
) (
  // Clock and reset.
  input  wire              clk,
  input  wire              rst,
  // Wishbone slave.
  input  wire              wb_cyc_i,
  input  wire              wb_stb_i,
  input  wire              wb_we_i,
  input  wire [ADDR_W-1:0] wb_adr_i,
  input  wire [3:0]        wb_sel_i,
  input  wire [31:0]       wb_dat_i,
  output reg  [31:0]       wb_dat_o,
  output reg               wb_ack_o,
  // Dedicated input pins.
  input  wire [INPUTS-1:0] in_pins,
  input  wire              pin_first,
  input  wire              pin_tenth_n,
  // Macrocell pins.
  input  wire [CELLS-1:0]  cell_in,
  output reg  [CELLS-1:0]  cell_out,
  output reg  [CELLS-1:0]  cell_oe
);

  localparam TERMS_PER = 8;
  localparam NTERMS    = CELLS * TERMS_PER;
  localparam NSIG      = INPUTS + CELLS;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration and state registers.
  reg [1:0]        global_cfg_reg;
  reg [CELLS-1:0]  polarity_reg;
  reg [CELLS-1:0]  io_select_reg;
  reg [CELLS-1:0]  drive_type_reg;
  reg [31:0]       term_dis_lo_reg;
  reg [31:0]       term_dis_hi_reg;
  reg [31:0]       signature_lo_reg;
  reg [31:0]       signature_hi_reg;
  reg [CELLS-1:0]  cell_q_reg;
  reg              pin_first_prev_reg;
  reg [31:0]       row_mem [0:NTERMS-1];

  wire [1:0] mode = {global_cfg_reg[`BIT_GLOBAL_CTRL], global_cfg_reg[`BIT_SYNC_MODE]};
  wire is_reg  = (mode == `MODE_REGISTERED);
  wire is_cplx = (mode == `MODE_COMPLEX);
  wire [CELLS-1:0] center_cells = `CENTER_MASK;

  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  sel;
    integer b;
    begin
      merge = old_v;
      for (b = 0; b < 4; b = b + 1) begin
        if (sel[b]) begin
          merge[b*8 +: 8] = new_v[b*8 +: 8];
        end
      end
    end
  endfunction

  function term_val;
    input [31:0] row;
    input [31:0] lit;
    input        dis;
    begin
      term_val = ~dis & (&(~row | lit));
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Product-term array and macrocell logic.
  reg [NSIG-1:0]   sig;
  reg [2*NSIG-1:0] lit;
  reg [NTERMS-1:0] term;
  reg [CELLS-1:0]  sum_all;
  reg [CELLS-1:0]  data;
  reg [CELLS-1:0]  en;
  reg [CELLS-1:0]  out_next;
  reg [CELLS-1:0]  oe_next;
  integer i;

  always @* begin
    sig = {NSIG{1'b0}};
    lit = {2*NSIG{1'b0}};
    term = {NTERMS{1'b0}};
    sum_all = {CELLS{1'b0}};
    data = {CELLS{1'b0}};
    en = {CELLS{1'b0}};
    out_next = {CELLS{1'b0}};
    oe_next = {CELLS{1'b0}};
    sig[INPUTS-1:0] = in_pins;
    for (i = 0; i < CELLS; i = i + 1) begin
      if (is_reg) begin
        // Feedback slots carry register state or I/O pin, never pin one/ten.
        sig[INPUTS+i] = io_select_reg[i] ? cell_in[i] : cell_q_reg[i];
      end else if (i == `CELL_OUTER_FIRST) begin
        sig[INPUTS+i] = pin_first;
      end else if (i == `CELL_OUTER_LAST) begin
        sig[INPUTS+i] = pin_tenth_n;
      end else if (is_cplx) begin
        sig[INPUTS+i] = cell_in[i];
      end else if (i < CELLS/2) begin
        // Inner slots take the outward neighbour, so the center pair never feeds back.
        sig[INPUTS+i] = cell_in[i-1];
      end else begin
        sig[INPUTS+i] = cell_in[i+1];
      end
    end
    for (i = 0; i < NSIG; i = i + 1) begin
      lit[2*i]   = sig[i];
      lit[2*i+1] = ~sig[i];
    end
    for (i = 0; i < NTERMS; i = i + 1) begin
      term[i] = term_val(row_mem[i], lit,
                         (i < 32) ? term_dis_lo_reg[i] : term_dis_hi_reg[i-32]);
    end
    for (i = 0; i < CELLS; i = i + 1) begin
      sum_all[i] = |term[i*TERMS_PER +: TERMS_PER];
      if (is_reg && !io_select_reg[i]) begin
        data[i] = cell_q_reg[i] ^ polarity_reg[i];
        en[i] = ~pin_tenth_n;
      end else if (is_reg || is_cplx) begin
        // First term of the cell is its enable; the other seven form the sum.
        data[i] = (|term[i*TERMS_PER+1 +: TERMS_PER-1]) ^ polarity_reg[i];
        en[i] = term[i*TERMS_PER];
      end else begin
        data[i] = sum_all[i] ^ polarity_reg[i];
        en[i] = ~io_select_reg[i] | center_cells[i];
      end
      if (drive_type_reg[i]) begin
        out_next[i] = 1'b0;
        oe_next[i] = en[i] & ~data[i];
      end else begin
        out_next[i] = data[i];
        oe_next[i] = en[i];
      end
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cell_out <= {CELLS{1'b0}};
      cell_oe <= {CELLS{1'b0}};
    end else begin
      cell_out <= out_next;
      cell_oe <= oe_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: ack one cycle after the request, write on the ack edge.
  wire req = wb_cyc_i & wb_stb_i;
  wire row_hit = wb_adr_i[`ROW_REGION_BIT] & ~|wb_adr_i[ADDR_W-1:`ROW_REGION_BIT+1];
  wire [5:0] row_idx = wb_adr_i[7:2];
  wire wr = req & wb_ack_o & wb_we_i;
  wire wr_pre = wr & (wb_adr_i == `OFF_PRELOAD) & wb_sel_i[0];
  wire clk_rise = is_reg & pin_first & ~pin_first_prev_reg;
  reg [31:0] rd_data;
  integer r;

  always @* begin
    rd_data = 32'h00000000;
    if (row_hit) begin
      rd_data = row_mem[row_idx];
    end else begin
      case (wb_adr_i)
        `OFF_GLOBAL_CFG:   rd_data[1:0] = global_cfg_reg;
        `OFF_POLARITY:     rd_data[CELLS-1:0] = polarity_reg;
        `OFF_IO_SELECT:    rd_data[CELLS-1:0] = io_select_reg;
        `OFF_DRIVE_TYPE:   rd_data[CELLS-1:0] = drive_type_reg;
        `OFF_TERM_DIS_LO:  rd_data = term_dis_lo_reg;
        `OFF_TERM_DIS_HI:  rd_data = term_dis_hi_reg;
        `OFF_SIGNATURE_LO: rd_data = signature_lo_reg;
        `OFF_SIGNATURE_HI: rd_data = signature_hi_reg;
        `OFF_PRELOAD:      rd_data[CELLS-1:0] = cell_q_reg;
        `OFF_STATUS: begin
          rd_data[CELLS-1:0] = cell_in;
          rd_data[CELLS+INPUTS-1:CELLS] = in_pins;
          rd_data[`STAT_PIN_FIRST] = pin_first;
          rd_data[`STAT_PIN_TENTH] = pin_tenth_n;
          rd_data[`STAT_MODE_LSB+1:`STAT_MODE_LSB] = mode;
        end
        default:           rd_data = 32'h00000000;
      endcase
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      global_cfg_reg <= `RST_GLOBAL_CFG;
      polarity_reg <= `RST_CELL_BITS;
      io_select_reg <= `RST_CELL_BITS;
      drive_type_reg <= `RST_CELL_BITS;
      term_dis_lo_reg <= `RST_TERM_DIS;
      term_dis_hi_reg <= `RST_TERM_DIS;
      signature_lo_reg <= `RST_SIGNATURE;
      signature_hi_reg <= `RST_SIGNATURE;
      cell_q_reg <= {CELLS{1'b0}};
      pin_first_prev_reg <= 1'b0;
      for (r = 0; r < NTERMS; r = r + 1) begin
        row_mem[r] <= `RST_ROW;
      end
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
      if (req & ~wb_ack_o) begin
        wb_dat_o <= rd_data;
      end
      pin_first_prev_reg <= pin_first;
      if (wr_pre) begin
        cell_q_reg <= wb_dat_i[CELLS-1:0];
      end else if (clk_rise) begin
        for (r = 0; r < CELLS; r = r + 1) begin
          if (!io_select_reg[r]) begin
            cell_q_reg[r] <= sum_all[r];
          end
        end
      end
      if (wr && row_hit) begin
        row_mem[row_idx] <= merge(row_mem[row_idx], wb_dat_i, wb_sel_i);
      end else if (wr) begin
        case (wb_adr_i)
          `OFF_GLOBAL_CFG: begin
            if (wb_sel_i[0]) begin
              global_cfg_reg <= wb_dat_i[1:0];
            end
          end
          `OFF_POLARITY: begin
            if (wb_sel_i[0]) begin
              polarity_reg <= wb_dat_i[CELLS-1:0];
            end
          end
          `OFF_IO_SELECT: begin
            if (wb_sel_i[0]) begin
              io_select_reg <= wb_dat_i[CELLS-1:0];
            end
          end
          `OFF_DRIVE_TYPE: begin
            if (wb_sel_i[0]) begin
              drive_type_reg <= wb_dat_i[CELLS-1:0];
            end
          end
          `OFF_TERM_DIS_LO:  term_dis_lo_reg <= merge(term_dis_lo_reg, wb_dat_i, wb_sel_i);
          `OFF_TERM_DIS_HI:  term_dis_hi_reg <= merge(term_dis_hi_reg, wb_dat_i, wb_sel_i);
          `OFF_SIGNATURE_LO: signature_lo_reg <= merge(signature_lo_reg, wb_dat_i, wb_sel_i);
          `OFF_SIGNATURE_HI: signature_hi_reg <= merge(signature_hi_reg, wb_dat_i, wb_sel_i);
          default: begin
          end
        endcase
      end
    end
  end

endmodule // macrocell_array

// *** hdl/macrocell_array_defines.vh ***
`ifndef MACROCELL_ARRAY_DEFINES_VH
`define MACROCELL_ARRAY_DEFINES_VH

// Register byte offsets.
`define OFF_GLOBAL_CFG   10'h000
`define OFF_POLARITY     10'h004
`define OFF_IO_SELECT    10'h008
`define OFF_DRIVE_TYPE   10'h00c
`define OFF_TERM_DIS_LO  10'h010
`define OFF_TERM_DIS_HI  10'h014
`define OFF_SIGNATURE_LO 10'h018
`define OFF_SIGNATURE_HI 10'h01c
`define OFF_PRELOAD      10'h020
`define OFF_STATUS       10'h024
`define ROW_REGION_BIT   8

// Global configuration fields.
`define BIT_SYNC_MODE    0
`define BIT_GLOBAL_CTRL  1

// Mode codes as {global_arch_control_bit, sync_mode_select_bit}.
`define MODE_SIMPLE      2'h1
`define MODE_COMPLEX     2'h3
`define MODE_REGISTERED  2'h2

// Status field positions.
`define STAT_PIN_FIRST   16
`define STAT_PIN_TENTH   17
`define STAT_MODE_LSB    18

// Reset values.
`define RST_GLOBAL_CFG   2'h1
`define RST_CELL_BITS    8'h00
`define RST_TERM_DIS     32'hffffffff
`define RST_SIGNATURE    32'h00000000
`define RST_ROW          32'h00000000

// Cell groups: outer cells and the center pair.
`define CELL_OUTER_FIRST 0
`define CELL_OUTER_LAST  7
`define CENTER_MASK      8'h18

`endif
